// [flash_seq_pkg.sv]
// constants shared by the serial flash operating-state logic
// assumes a 200 MHz system clock; times are in microseconds or milliseconds
package flash_seq_pkg;

  localparam int unsigned CLK_MHZ = 200;

  // opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ       = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE        = 8'h02;
  localparam logic [7:0] OP_SECTOR_CLEAR      = 8'hD8;
  localparam logic [7:0] OP_FULL_CLEAR        = 8'hC7;
  localparam logic [7:0] OP_SLEEP             = 8'hB9;
  localparam logic [7:0] OP_WAKE              = 8'hAB;

  // byte counts that a write-class command must end on (page write: at least LEN_PAGE); LEN_MAX caps the count
  localparam logic [9:0] LEN_SHORT   = 10'h001;
  localparam logic [9:0] LEN_STATUS  = 10'h002;
  localparam logic [9:0] LEN_SECTOR  = 10'h004;
  localparam logic [9:0] LEN_PAGE    = 10'h005;
  localparam logic [9:0] LEN_MAX     = 10'h3FF;

  // status byte layout
  localparam int unsigned ST_CYCLE_BIT = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_PROT_LSB  = 2;
  localparam int unsigned ST_LOCK_BIT  = 7;
  localparam logic [2:0]  PROT_RESET   = 3'h0;
  localparam logic        LOCK_RESET   = 1'b0;

  // internal cycle times, plain defaults
  localparam int unsigned PROGRAM_CYCLE_TIME_US = 1000;
  localparam int unsigned SECTOR_CLEAR_TIME_MS  = 1000;
  localparam int unsigned FULL_CLEAR_TIME_MS    = 10000;
  localparam int unsigned STATUS_WRITE_TIME_US  = 10000;
  localparam int unsigned PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
  localparam int unsigned SECTOR_CYCLES  = SECTOR_CLEAR_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned FULL_CYCLES    = FULL_CLEAR_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned STATUS_CYCLES  = STATUS_WRITE_TIME_US * CLK_MHZ;

  // page staging and array stream
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned FIFO_WIDTH = 16;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned SYNC_PINS  = 5;
  // idle levels of {sclk, cs_n, mosi, hold_n, wp_n}, so no false edge follows reset
  localparam logic [4:0]  SYNC_IDLE  = 5'h0B;

  // power mode output, one-hot
  localparam logic [2:0] PM_ACTIVE  = 3'h1;
  localparam logic [2:0] PM_STANDBY = 3'h2;
  localparam logic [2:0] PM_DEEP    = 3'h4;

  typedef enum logic [3:0] {
    CYC_IDLE  = 4'h1,
    CYC_PROG  = 4'h2,
    CYC_ERASE = 4'h4,
    CYC_SWR   = 4'h8
  } cycle_state_t;

endpackage : flash_seq_pkg

// [pin_sync.sv]
// two-stage synchroniser, one per pin
// assumes the pins are asynchronous to the system clock
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned        WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          meta      <= RST_VAL[g];
          o_sync[g] <= RST_VAL[g];
        end else begin
          meta      <= i_pins[g];
          o_sync[g] <= meta;
        end
      end
    end
  endgenerate
endmodule : pin_sync

// [stream_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/10ps
module stream_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_empty
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign o_empty     = (wr_ptr == rd_ptr);
  assign o_in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign o_out_valid = !o_empty;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : stream_fifo

// [flash_seq.sv]
// operating-state logic of a serial nor flash behind a four-wire serial slave port
// assumes pins are asynchronous and the array sits behind the program/erase ports
// How it works
// R1: host sets the write latch, then sends page write with three address bytes and data.
// R2: a page write holds up to 256 bytes in one page; bits only go low.
// R3: host should send consecutive bytes in one page write for throughput.
// R4: bytes are erased to all ones by sector clear or full clear cycles.
// R5: host sets the write latch before every erase or it is skipped.
// R6: cycle active flag is high while status write, program or erase runs.
// R7: chip select low means selected and active power.
// R8: deselected device stays active until its internal cycle ends, then standby.
// R9: sleep enters deep power-down; only wake leaves it.
// R10: in deep power-down all write, program and erase commands are ignored.
// R11: write-class commands run only when clock count is a multiple of eight.
// R12: data-changing commands run only with the write latch set.
// R13: write latch clears at reset and at end of each write-class command.
// R14: three protect bits choose the read-only top sectors.
// R15: write protect pin locks protect and lock bits when lock bit is set.
// R16: pause needs chip select low and never aborts an internal cycle.
// R17: pause starts on pause fall if clock low, else on next clock fall.
// R18: pause ends on pause rise if clock low, else on next clock fall.
// R19: during pause output floats and clock and input are ignored.
// R20: chip select rising during pause resets the serial logic.
// R21: host should hold chip select low for the whole pause.
// R22: full clear runs only when all protect bits are zero.
// R23: all bytes move most significant bit first.
// R24: write-class commands need chip select to rise on a byte boundary.
// R25: input sampled on clock rise, output changes after clock fall.
// R26: array access during an internal cycle is ignored, cycle continues.
// R27: writes or clears into protected sectors change nothing but clear the latch; a full clear refused for set protect bits leaves the latch set.
`timescale 1ns/10ps
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned PROG_CYC   = flash_seq_pkg::PROGRAM_CYCLES,
  parameter int unsigned SECTOR_CYC = flash_seq_pkg::SECTOR_CYCLES,
  parameter int unsigned FULL_CYC   = flash_seq_pkg::FULL_CYCLES,
  parameter int unsigned STATUS_CYC = flash_seq_pkg::STATUS_CYCLES
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic        i_hold_n,
  input  wire logic        i_wp_n,
  output logic             o_miso,
  output logic             o_miso_oe,
  // array program stream: {byte offset, data}
  output logic             o_arr_valid,
  input  wire logic        i_arr_ready,
  output logic [15:0]      o_arr_data,
  output logic [15:0]      o_arr_page,
  // array erase
  output logic             o_erase_sector,
  output logic             o_erase_all,
  output logic [4:0]       o_erase_index,
  // state
  output logic [7:0]       o_status,
  output logic [2:0]       o_power_mode,
  output logic             o_hold_active
);
  import flash_seq_pkg::*;

  logic [4:0]    pins;
  logic          s_sclk, s_cs_n, s_mosi, s_hold_n, s_wp_n;
  logic          sclk_prev, cs_prev, hold_prev;
  logic          sclk_rise, sclk_fall, cs_rise, cs_fall, selected;
  logic          hold, enter_pend, exit_pend;
  logic [2:0]    bit_cnt;
  logic [9:0]    byte_cnt;
  logic [6:0]    shreg;
  logic [7:0]    opcode, next_byte, sw_data;
  logic [23:0]   addr;
  logic [7:0]    pbuf [PAGE_BYTES];
  logic [255:0]  pmask;
  logic          wake_seen;
  cycle_state_t  state;
  logic [31:0]   timer;
  logic          wl, pd, lock, sw_apply;
  logic [2:0]    prot;
  logic [8:0]    walk_idx;
  logic          push_valid, fifo_ready, fifo_empty;
  logic          page_prot, sector_prot, rd_mode;
  logic [7:0]    status_now;

  pin_sync #(.WIDTH(SYNC_PINS), .RST_VAL(SYNC_IDLE)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pins    ({i_sclk, i_cs_n, i_mosi, i_hold_n, i_wp_n}),
    .o_sync    (pins)
  );
  assign {s_sclk, s_cs_n, s_mosi, s_hold_n, s_wp_n} = pins;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
      hold_prev <= 1'b1;
    end else begin
      sclk_prev <= s_sclk;
      cs_prev   <= s_cs_n;
      hold_prev <= s_hold_n;
    end
  end
  assign sclk_rise = s_sclk && !sclk_prev;
  assign sclk_fall = !s_sclk && sclk_prev;
  assign cs_rise   = s_cs_n && !cs_prev;
  assign cs_fall   = !s_cs_n && cs_prev;
  assign selected  = !s_cs_n;

  // protected when sector index reaches the level's lower bound
  function automatic logic is_prot(input logic [2:0] lvl, input logic [4:0] sec);
    logic [5:0] lo;
    case (lvl)
      3'h0:    lo = 6'h20;
      3'h1:    lo = 6'h1F;
      3'h2:    lo = 6'h1E;
      3'h3:    lo = 6'h1C;
      3'h4:    lo = 6'h18;
      3'h5:    lo = 6'h10;
      default: lo = 6'h00;
    endcase
    return {1'b0, sec} >= lo; // R14
  endfunction
  assign page_prot   = is_prot(prot, addr[20:16]); // R27
  assign sector_prot = page_prot;

  // pause tracking; a deselect drops it and any pending edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hold       <= 1'b0;
      enter_pend <= 1'b0;
      exit_pend  <= 1'b0;
    end else if (!selected) begin
      hold       <= 1'b0; // R16 R20
      enter_pend <= 1'b0;
      exit_pend  <= 1'b0;
    end else if (!s_hold_n && hold_prev && !hold) begin
      hold       <= !s_sclk; // R17
      enter_pend <= s_sclk;
      exit_pend  <= 1'b0;
    end else if (s_hold_n && !hold_prev && (hold || enter_pend)) begin
      hold       <= hold && s_sclk; // R18
      exit_pend  <= hold && s_sclk;
      enter_pend <= 1'b0;
    end else if (sclk_fall && enter_pend) begin
      hold       <= 1'b1; // R17
      enter_pend <= 1'b0;
    end else if (sclk_fall && exit_pend) begin
      hold       <= 1'b0; // R18
      exit_pend  <= 1'b0;
    end
  end

  // serial shift-in, msb first on clock rise; clock ignored while paused
  assign next_byte = {shreg, s_mosi}; // R23
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt   <= 3'h0;
      byte_cnt  <= 10'h000;
      shreg     <= 7'h00;
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      sw_data   <= 8'h00;
      pmask     <= '0;
      wake_seen <= 1'b0;
    end else begin
      wake_seen <= 1'b0;
      if (!selected) begin
        bit_cnt  <= 3'h0; // R20
        byte_cnt <= 10'h000;
      end else if (sclk_rise && !hold) begin // R19 R25
        bit_cnt <= bit_cnt + 3'h1;
        shreg   <= next_byte[6:0];
        if (bit_cnt == 3'h7) begin
          if (byte_cnt != LEN_MAX) byte_cnt <= byte_cnt + 10'h001;
          case (byte_cnt)
            10'h000: begin
              opcode    <= next_byte;
              wake_seen <= (next_byte == OP_WAKE); // R9
            end
            10'h001: begin
              addr[23:16] <= next_byte;
              sw_data     <= next_byte;
            end
            10'h002: addr[15:8] <= next_byte;
            10'h003: addr[7:0]  <= next_byte;
            default: begin
              // data wraps inside the page; a busy device leaves the buffer alone
              if (opcode == OP_PAGE_WRITE && state == CYC_IDLE) begin // R2 R26
                addr[7:0] <= addr[7:0] + 8'h01;
                pmask[addr[7:0]] <= 1'b1;
              end
            end
          endcase
        end
      end
      if (cs_fall && state == CYC_IDLE) pmask <= '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (selected && sclk_rise && !hold && bit_cnt == 3'h7 && byte_cnt >= LEN_SECTOR
        && opcode == OP_PAGE_WRITE && state == CYC_IDLE) begin
      pbuf[addr[7:0]] <= next_byte;
    end
  end

  // command execution at deselect, cycle engine and status bits
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state          <= CYC_IDLE;
      timer          <= 32'h0000_0000;
      wl             <= 1'b0; // R13
      pd             <= 1'b0;
      prot           <= PROT_RESET;
      lock           <= LOCK_RESET;
      sw_apply       <= 1'b0;
      walk_idx       <= 9'h000;
      o_arr_page     <= 16'h0000;
      o_erase_sector <= 1'b0;
      o_erase_all    <= 1'b0;
      o_erase_index  <= 5'h00;
    end else begin
      o_erase_sector <= 1'b0;
      o_erase_all    <= 1'b0;
      if (wake_seen) pd <= 1'b0; // R9
      if (timer != 32'h0000_0000) timer <= timer - 32'h0000_0001;
      case (state)
        CYC_IDLE: begin
          // a deselect during pause, off a byte boundary, asleep or busy runs nothing
          if (cs_rise && !hold && bit_cnt == 3'h0 && !pd) begin // R10 R11 R20 R24
            case (opcode)
              OP_WRITE_LATCH_SET:   if (byte_cnt == LEN_SHORT) wl <= 1'b1;
              OP_WRITE_LATCH_CLEAR: if (byte_cnt == LEN_SHORT) wl <= 1'b0; // R13
              OP_SLEEP:             if (byte_cnt == LEN_SHORT) pd <= 1'b1; // R9
              OP_STATUS_WRITE: if (byte_cnt == LEN_STATUS && wl) begin // R12
                state    <= CYC_SWR;
                timer    <= 32'(STATUS_CYC);
                sw_apply <= !(lock && !s_wp_n); // R15
              end
              OP_PAGE_WRITE: if (byte_cnt >= LEN_PAGE && wl) begin // R1 R12
                if (page_prot) wl <= 1'b0; // R27
                else begin
                  state      <= CYC_PROG;
                  timer      <= 32'(PROG_CYC);
                  walk_idx   <= 9'h000;
                  o_arr_page <= addr[23:8];
                end
              end
              OP_SECTOR_CLEAR: if (byte_cnt == LEN_SECTOR && wl) begin // R4 R5 R12
                if (sector_prot) wl <= 1'b0; // R27
                else begin
                  state          <= CYC_ERASE;
                  timer          <= 32'(SECTOR_CYC);
                  o_erase_sector <= 1'b1;
                  o_erase_index  <= addr[20:16];
                end
              end
              OP_FULL_CLEAR: if (byte_cnt == LEN_SHORT && wl && prot == 3'h0) begin // R22
                state       <= CYC_ERASE;
                timer       <= 32'(FULL_CYC);
                o_erase_all <= 1'b1; // R4
              end
              default: ;
            endcase
          end
        end
        CYC_PROG: begin
          // walk the staged page; a full fifo stalls the walk
          if (!walk_idx[8] && (!pmask[walk_idx[7:0]] || fifo_ready)) begin
            walk_idx <= walk_idx + 9'h001;
          end
          if (walk_idx[8] && fifo_empty && timer == 32'h0000_0000) begin
            state <= CYC_IDLE;
            wl    <= 1'b0; // R13
          end
        end
        CYC_ERASE: begin
          if (timer == 32'h0000_0000) begin
            state <= CYC_IDLE;
            wl    <= 1'b0; // R13
          end
        end
        CYC_SWR: begin
          if (timer == 32'h0000_0000) begin
            state <= CYC_IDLE;
            wl    <= 1'b0; // R13
            if (sw_apply) begin // R15
              prot <= sw_data[ST_PROT_LSB +: 3];
              lock <= sw_data[ST_LOCK_BIT];
            end
          end
        end
        default: state <= CYC_IDLE;
      endcase
    end
  end

  assign push_valid = (state == CYC_PROG) && !walk_idx[8] && pmask[walk_idx[7:0]];

  stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({walk_idx[7:0], pbuf[walk_idx[7:0]]}),
    .o_out_valid (o_arr_valid),
    .i_out_ready (i_arr_ready),
    .o_out_data  (o_arr_data),
    .o_empty     (fifo_empty)
  );

  always_comb begin
    status_now                         = 8'h00;
    status_now[ST_CYCLE_BIT]           = (state != CYC_IDLE); // R6
    status_now[ST_LATCH_BIT]           = wl;
    status_now[ST_PROT_LSB +: 3]       = prot;
    status_now[ST_LOCK_BIT]            = lock;
  end
  assign rd_mode = (opcode == OP_STATUS_READ) && (byte_cnt != 10'h000) && !pd;

  // status read repeats while selected; output moves only after a clock fall
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_miso        <= 1'b0;
      o_miso_oe     <= 1'b0;
      o_status      <= 8'h00;
      o_power_mode  <= PM_STANDBY;
      o_hold_active <= 1'b0;
    end else begin
      o_status      <= status_now;
      o_hold_active <= hold;
      o_miso_oe     <= selected && !hold && rd_mode; // R19
      if (selected && !hold && sclk_fall && rd_mode) begin // R25
        o_miso <= status_now[3'h7 - bit_cnt]; // R23
      end
      if (pd) o_power_mode <= PM_DEEP; // R9
      else if (selected || state != CYC_IDLE) o_power_mode <= PM_ACTIVE; // R7 R8
      else o_power_mode <= PM_STANDBY; // R8
    end
  end

  a_latch_end_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R13
    $fell(o_status[ST_CYCLE_BIT]) |-> !wl)
    else $error("write latch still set after cycle end");
  a_sleep_ignores: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R10
    (pd && cs_rise && state == CYC_IDLE) |=> state == CYC_IDLE)
    else $error("cycle started in deep power-down");
  a_odd_bits_reject: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R11
    (cs_rise && bit_cnt != 3'h0 && state == CYC_IDLE) |=> (state == CYC_IDLE && wl == $past(wl)))
    else $error("command ran off a byte boundary");
  a_cycle_needs_latch: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R12
    (state == CYC_IDLE ##1 state != CYC_IDLE) |-> $past(wl))
    else $error("cycle started without write latch");
  a_full_clear_prot: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R22
    $rose(o_erase_all) |-> prot == 3'h0)
    else $error("full clear with protect bits set");
  a_pause_floats: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R19
    hold |=> !o_miso_oe)
    else $error("output driven during pause");
  a_busy_active: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
    (state != CYC_IDLE && !pd) |=> o_power_mode == PM_ACTIVE)
    else $error("standby during internal cycle");
  a_select_active: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R7
    (selected && !pd) |=> (o_power_mode == PM_ACTIVE || pd))
    else $error("selected device not active");
  a_pause_keeps_cycle: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R16
    (hold && state == CYC_ERASE && timer > 32'h0000_0001) |=> state == CYC_ERASE)
    else $error("pause aborted erase cycle");
endmodule : flash_seq

// [spi_host_model.sv]
// serial bus master model driving the flash pins in clock mode 0
// assumes the system clock paces it: one serial half period is 16 system clocks
`timescale 1ns/10ps
module spi_host_model (
  // pacing clock
  input  wire logic i_sys_clk,
  // serial pins toward the device
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  output logic      o_hold_n,
  // serial data back from the device, taken on each clock rise
  input  wire logic i_miso,
  output logic [7:0] o_rx
);
  initial begin
    o_sclk   = 1'b0; // clock stands low outside frames
    o_cs_n   = 1'b1;
    o_mosi   = 1'b0;
    o_hold_n = 1'b1;
    o_rx     = 8'h00;
  end
  // 80 ns half period, far above four system clocks per phase
  task automatic half();
    repeat (16) @(posedge i_sys_clk);
  endtask : half
  task automatic start();
    o_cs_n <= 1'b0;
    half();
  endtask : start
  // data changes in the low phase so the device latches it on the rise
  task automatic shift(input logic [63:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= bits[i];
      half();
      o_sclk <= 1'b1;
      o_rx   <= {o_rx[6:0], i_miso};
      half();
      o_sclk <= 1'b0;
    end
    half();
  endtask : shift
  task automatic stop();
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi; // a released line must not keep showing the last bit
    half();
  endtask : stop
  // pause pin is only moved while the clock is low
  task automatic set_hold(input logic v);
    o_hold_n <= v;
    half();
  endtask : set_hold
endmodule : spi_host_model

// [tb_serial_flash_write_protect_hold.sv]
// self-checking bench for the flash operating-state logic
// assumes shortened cycle times so each internal cycle ends within a few serial bytes
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_flash_write_protect_hold;
  import flash_seq_pkg::*;
  logic        i_sys_clk, i_rst, sclk, cs_n, mosi, hold_n, i_wp_n, i_arr_ready;
  logic        o_miso, o_miso_oe, o_arr_valid, o_erase_sector, o_erase_all, o_hold_active;
  logic [15:0] o_arr_data, o_arr_page, first_word;
  logic [4:0]  o_erase_index;
  logic [7:0]  o_status, rx;
  logic        arr_go;
  logic [1:0]  beat;
  logic [2:0]  o_power_mode;
  int          errors, num_checks, n_sec, n_all, n_words;

  spi_host_model host (.i_sys_clk(i_sys_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .o_hold_n(hold_n), .i_miso(o_miso), .o_rx(rx));
  flash_seq #(.PROG_CYC(50), .SECTOR_CYC(50), .FULL_CYC(80), .STATUS_CYC(40)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .o_arr_valid(o_arr_valid), .i_arr_ready(i_arr_ready), .o_arr_data(o_arr_data),
    .o_arr_page(o_arr_page), .o_erase_sector(o_erase_sector), .o_erase_all(o_erase_all),
    .o_erase_index(o_erase_index), .o_status(o_status), .o_power_mode(o_power_mode),
    .o_hold_active(o_hold_active));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // pulses last one clock, so they are counted rather than sampled
  always @(posedge i_sys_clk) begin
    beat        <= i_rst ? 2'h0 : beat + 2'h1;
    i_arr_ready <= arr_go && beat != 2'h3; // array stalls every fourth clock
    if (o_erase_sector === 1'b1) n_sec++;
    if (o_erase_all === 1'b1) n_all++;
    if (o_arr_valid === 1'b1 && i_arr_ready === 1'b1) begin
      if (n_words == 0) first_word = o_arr_data;
      n_words++;
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : settle
  task automatic cmd(input logic [63:0] bits, input int n);
    host.start();
    host.shift(bits, n);
    host.stop();
    settle(8);
  endtask : cmd
  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && o_status[ST_CYCLE_BIT] !== 1'b0; k++) settle(1);
    if (k == 3000) begin
      errors++;
      $display("MISMATCH %0t cycle flag stuck", $time);
    end
  endtask : wait_idle
  task automatic t_page();
    cmd(OP_WRITE_LATCH_SET, 8);
    `CHK(o_status[ST_LATCH_BIT], 1'b1);
    host.start();
    `CHK(o_power_mode, PM_ACTIVE);
    host.shift({OP_PAGE_WRITE, 24'h000100, 8'hA5, 8'h3C, 8'h0F}, 56);
    host.stop();
    settle(8);
    `CHK(o_status[ST_CYCLE_BIT], 1'b1);
    `CHK(o_arr_page, 16'h0001);
    `CHK(o_arr_valid, 1'b1);
    cmd(OP_WRITE_LATCH_CLEAR, 8);
    `CHK(o_status[ST_LATCH_BIT], 1'b1);
    `CHK(o_power_mode, PM_ACTIVE);
    host.start();
    host.shift(OP_STATUS_READ, 8);
    `CHK(o_miso_oe, 1'b1);
    host.shift(8'h00, 8);
    host.stop();
    settle(8);
    `CHK(rx, 8'h03);
    arr_go <= 1'b1;
    wait_idle();
    `CHK(n_words, 3);
    `CHK(first_word, 16'h00A5);
    `CHK(o_status[ST_LATCH_BIT], 1'b0);
    `CHK(o_power_mode, PM_STANDBY);
  endtask : t_page
  task automatic t_reject();
    cmd({OP_PAGE_WRITE, 24'h000200, 8'h11}, 40);
    `CHK(o_arr_valid, 1'b0);
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd({OP_SECTOR_CLEAR, 24'h030000, 1'b0}, 33);
    `CHK(n_sec, 0);
    `CHK(o_status[ST_LATCH_BIT], 1'b1);
    cmd(OP_WRITE_LATCH_CLEAR, 8);
    `CHK(o_status[ST_LATCH_BIT], 1'b0);
  endtask : t_reject
  task automatic t_erase();
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd({OP_SECTOR_CLEAR, 24'h030000}, 32);
    `CHK(n_sec, 1);
    `CHK(o_erase_index, 5'h03);
    wait_idle();
    `CHK(o_status[ST_LATCH_BIT], 1'b0);
    cmd({OP_SECTOR_CLEAR, 24'h030000}, 32);
    `CHK(n_sec, 1);
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd(OP_FULL_CLEAR, 8);
    `CHK(n_all, 1);
    host.start();
    host.set_hold(1'b0);
    `CHK(o_status[ST_CYCLE_BIT], 1'b1);
    host.set_hold(1'b1);
    host.stop();
    wait_idle();
  endtask : t_erase
  task automatic swr(input logic [7:0] v);
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd({OP_STATUS_WRITE, v}, 16);
    wait_idle();
  endtask : swr
  task automatic t_protect();
    swr(8'h84);
    `CHK(o_status[4:2], 3'h1);
    i_wp_n <= 1'b0;
    swr(8'h00);
    `CHK(o_status, 8'h84);
    i_wp_n <= 1'b1;
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd(OP_FULL_CLEAR, 8);
    `CHK(n_all, 1);
    cmd({OP_SECTOR_CLEAR, 24'h1F0000}, 32);
    `CHK(n_sec, 1);
    `CHK(o_status[ST_LATCH_BIT], 1'b0);
    cmd(OP_WRITE_LATCH_SET, 8);
    cmd({OP_SECTOR_CLEAR, 24'h1E0000}, 32);
    `CHK(n_sec, 2);
    wait_idle();
    swr(8'h00);
    `CHK(o_status, 8'h00);
  endtask : t_protect
  task automatic t_sleep();
    cmd(OP_SLEEP, 8);
    `CHK(o_power_mode, PM_DEEP);
    cmd(OP_WRITE_LATCH_SET, 8);
    `CHK(o_status[ST_LATCH_BIT], 1'b0);
    `CHK(o_power_mode, PM_DEEP);
    cmd(OP_WAKE, 8);
    `CHK(o_power_mode, PM_STANDBY);
  endtask : t_sleep
  task automatic t_hold();
    host.start();
    host.shift(4'h0, 4);
    host.set_hold(1'b0);
    `CHK(o_hold_active, 1'b1);
    `CHK(o_miso_oe, 1'b0);
    host.shift(4'hF, 4);
    host.set_hold(1'b1);
    `CHK(o_hold_active, 1'b0);
    host.shift(4'h6, 4);
    host.stop();
    settle(8);
    `CHK(o_status[ST_LATCH_BIT], 1'b1);
    cmd(OP_WRITE_LATCH_CLEAR, 8);
    host.start();
    host.shift(4'h0, 4);
    host.set_hold(1'b0);
    host.stop();
    host.set_hold(1'b1);
    cmd(OP_WRITE_LATCH_SET, 8);
    `CHK(o_status[ST_LATCH_BIT], 1'b1);
  endtask : t_hold
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    i_rst       = 1'b1;
    i_wp_n      = 1'b1;
    arr_go      = 1'b0;
    settle(2);
    i_rst <= 1'b0;
    settle(4);
    `CHK(o_status, 8'h00);
    `CHK(o_power_mode, PM_STANDBY);
    t_page();
    $display("page test done");
    t_reject();
    $display("reject test done");
    t_erase();
    $display("erase test done");
    t_protect();
    $display("protect test done");
    t_sleep();
    $display("sleep test done");
    t_hold();
    $display("hold test done");
    stop_test();
  end
  // whole sequence needs about 17500 clocks
  initial begin
    settle(80000);
    errors++;
    stop_test();
  end
endmodule : tb_serial_flash_write_protect_hold
